/* hw/pio_host_regs.svh */
// Constants for the counter/pio host bus interface
`ifndef PIO_HOST_REGS_SVH
`define PIO_HOST_REGS_SVH
`define SEL_PORT_C 2'h0
`define SEL_PORT_B 2'h1
`define SEL_PORT_A 2'h2
`define SEL_CTRL 2'h3
`define ADDR_BITS 6
`define REG_MIC 6'h00
`define REG_VECTOR 6'h02
`define REG_PORT_A 6'h0D
`define REG_PORT_B 6'h0E
`define REG_PORT_C 6'h0F
`define MIC_RESET_BIT 0
`define MIC_MIE_BIT 7
`define MIC_RJA_BIT 1
`define RESET_VAL 8'h01
`define ZERO_BYTE 8'h00
`define NUM_SRC 3
`define PIN_IDLE 23'h7F7C00
`endif

/* hw/pio_host_pkg.sv */
// Types shared by the counter/pio host bus interface
package pio_host_pkg;
    typedef enum logic [1:0] {
        CTL_POINTER = 2'h1,
        CTL_TARGET = 2'h2
    } ctl_state_t;
    typedef enum logic [2:0] {
        BUS_IDLE = 3'h1,
        BUS_ACCESS = 3'h2,
        BUS_RECOVER = 3'h4
    } bus_state_t;
endpackage

/* hw/strobe_sync.sv */
// Two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module strobe_sync #(
    parameter int WIDTH = 8
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [WIDTH-1:0] i_async,
    input wire logic [WIDTH-1:0] i_rst_val,
    output logic [WIDTH-1:0] o_sync
);
    if (WIDTH < 1)
    begin
        $error("WIDTH must be at least 1");
    end
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;
    always_comb
    begin
        meta_d = i_async;
        sync_d = meta_q;
        if (!i_rst_b)
        begin
            meta_d = i_rst_val;
            sync_d = i_rst_val;
        end
    end
    always_ff @(posedge i_clk)
    begin
        meta_q <= meta_d;
        sync_q <= sync_d;
    end
    assign o_sync = sync_q;
endmodule
`default_nettype wire

/* hw/pio_host_if.sv */
// Host bus interface of the counter/pio peripheral, both bus variants
//
// Functional notes
// - Multiplexed variant: address strobe edges time all transfers; host keeps it running.
// - Request asserts synchronous to the peripheral clock.
// - Multiplexed: address, chip select and ack cycle sampled while address strobe low.
// - chain_grant_out high only with chain_grant_in high and, out of reset, not servicing and no pending flag during acknowledge.
// - Open-drain service request low whenever a pending flag set, interrupts enabled and not in reset.
// - Both bus strobes low together resets the device.
// - Multiplexed: six address bits latched to pick the register, bits 5:0 with RJA, else bits 6:1.
// - Multiplexed read drives register while data strobe low; unknown address floats.
// - Multiplexed write captures bus data into addressed register on data strobe.
// - Multiplexed acknowledge with pending: grant low; vector driven and service flag set if granted.
// - Non-multiplexed control logic runs on the peripheral clock.
// - Two register select lines choose port C, B, A data or control.
// - Non-multiplexed register accesses respond only while chip select low; the acknowledge vector fetch does not need it.
// - Read strobe gates register, or vector in acknowledge if highest priority.
// - Non-multiplexed store strobe falling captures bus data into selected register.
// - Non-multiplexed acknowledge with pending: grant low; vector and service flag if granted.
// - Select 00 port C, 01 port B, 10 port A, 11 control.
// - Control accesses alternate pointer then target; any control read returns to pointer.
// - In reset only the reset bit responds; other writes ignored, reads zero.
`timescale 1ns/1ps
`default_nettype none
`include "pio_host_regs.svh"
module pio_host_if #(
    parameter int NSRC = `NUM_SRC
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_mux_mode,
    input wire logic i_address_strobe_b,
    input wire logic i_data_strobe_b,
    input wire logic i_direction_in,
    input wire logic i_chip_select_b,
    input wire logic i_read_strobe_b,
    input wire logic i_store_strobe_b,
    input wire logic [1:0] i_register_select_lines,
    input wire logic i_ack_cycle_b,
    input wire logic i_chain_grant_in,
    input wire logic [7:0] i_bus_in,
    input wire logic [NSRC-1:0] i_event,
    output logic [7:0] o_bus_out,
    output logic o_bus_oe,
    output logic o_chain_grant_out,
    output logic o_service_request_out,
    output logic o_service_request_oe,
    output logic o_in_reset,
    output logic [7:0] o_port_a,
    output logic [7:0] o_port_b,
    output logic [7:0] o_port_c,
    output logic [NSRC-1:0] o_pending_flag,
    output logic [NSRC-1:0] o_service_flag
);
    if (NSRC < 1 || NSRC > 4)
    begin
        $error("NSRC must be 1 to 4");
    end
    // Pins are asynchronous to i_clk: synchronise all strobes and data
    logic [22:0] raw_pins;
    logic [22:0] pins;
    assign raw_pins = {i_address_strobe_b, i_data_strobe_b, i_direction_in, i_chip_select_b,
                       i_read_strobe_b, i_store_strobe_b, i_register_select_lines,
                       i_ack_cycle_b, i_chain_grant_in, i_bus_in, 5'h00};
    strobe_sync #(.WIDTH(23)) u_sync (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_async(raw_pins),
        .i_rst_val(`PIN_IDLE),
        .o_sync(pins)
    );
    logic as_b, ds_b, dir, cs_b, rd_b, wr_b, ack_b, grant_in;
    logic [1:0] rsel;
    logic [7:0] bus;
    assign as_b = pins[22];
    assign ds_b = pins[21];
    assign dir = pins[20];
    assign cs_b = pins[19];
    assign rd_b = pins[18];
    assign wr_b = pins[17];
    assign rsel = pins[16:15];
    assign ack_b = pins[14];
    assign grant_in = pins[13];
    assign bus = pins[12:5];

    // Register state
    logic [7:0] mic_q, mic_d, vec_q, vec_d, pa_q, pa_d, pb_q, pb_d, pc_q, pc_d;
    logic [5:0] ptr_q, ptr_d, addr_q, addr_d;
    logic addr_cs_q, addr_cs_d, addr_ack_q, addr_ack_d;
    logic as_q, as_d, rd_q, rd_d, wr_q, wr_d, ds_q, ds_d;
    logic [NSRC-1:0] ip_q, ip_d, ius_q, ius_d;
    pio_host_pkg::ctl_state_t ctl_q, ctl_d;
    logic [7:0] out_q, out_d;
    logic oe_q, oe_d, vhold_q, vhold_d;

    logic in_reset, mie, strobe_reset, any_ip, any_ius;
    logic rd_fall, wr_fall, ds_fall, as_fall, ack_now;
    logic do_read, do_write, do_vector;
    logic [5:0] target;
    logic tgt_valid;
    logic [7:0] rdata;
    logic [1:0] hi_idx;
    assign in_reset = mic_q[`MIC_RESET_BIT];
    assign mie = mic_q[`MIC_MIE_BIT];
    assign any_ip = |ip_q;
    assign any_ius = |ius_q;
    assign strobe_reset = i_mux_mode ? (!as_b && !ds_b) : (!rd_b && !wr_b);
    assign as_fall = as_q && !as_b;
    assign ds_fall = ds_q && !ds_b;
    assign rd_fall = rd_q && !rd_b;
    assign wr_fall = wr_q && !wr_b;
    assign ack_now = i_mux_mode ? addr_ack_q : !ack_b;

    // Highest-priority pending source, lowest index wins
    always_comb
    begin
        hi_idx = 2'h0;
        for (int k = NSRC - 1; k >= 0; k--)
        begin
            if (ip_q[k])
                hi_idx = 2'(k);
        end
    end

    // Target selection for both variants
    always_comb
    begin
        target = ptr_q;
        if (i_mux_mode)
            target = addr_q;
        else
        begin
            case (rsel)
                `SEL_PORT_C: target = `REG_PORT_C;
                `SEL_PORT_B: target = `REG_PORT_B;
                `SEL_PORT_A: target = `REG_PORT_A;
                default: target = ptr_q;
            endcase
        end
        case (target)
            `REG_MIC, `REG_VECTOR, `REG_PORT_A, `REG_PORT_B, `REG_PORT_C: tgt_valid = 1'b1;
            default: tgt_valid = 1'b0;
        endcase
        case (target)
            `REG_MIC: rdata = mic_q;
            `REG_VECTOR: rdata = vec_q;
            `REG_PORT_A: rdata = pa_q;
            `REG_PORT_B: rdata = pb_q;
            `REG_PORT_C: rdata = pc_q;
            default: rdata = `ZERO_BYTE;
        endcase
        if (in_reset && target != `REG_MIC)
            rdata = `ZERO_BYTE;
        if (in_reset && target == `REG_MIC)
            rdata = {7'h00, mic_q[`MIC_RESET_BIT]};
    end

    // Access decode; pointer writes in the non-multiplexed control path are not register writes
    logic nm_ptr_phase;
    assign nm_ptr_phase = !i_mux_mode && rsel == `SEL_CTRL && ctl_q == pio_host_pkg::CTL_POINTER;
    // Fetch clears the pending bit, so a hold flag keeps the vector up for the whole strobe
    assign do_vector = ack_now && (any_ip || vhold_q) && grant_in
                       && (i_mux_mode ? !ds_b : !rd_b);
    assign do_read = !ack_now && (i_mux_mode ? (!ds_b && addr_cs_q && dir)
                                             : (!rd_b && !cs_b)) && tgt_valid;

    always_comb
    begin
        as_d = as_b;
        ds_d = ds_b;
        rd_d = rd_b;
        wr_d = wr_b;
        addr_d = addr_q;
        addr_cs_d = addr_cs_q;
        addr_ack_d = addr_ack_q;
        mic_d = mic_q;
        vec_d = vec_q;
        pa_d = pa_q;
        pb_d = pb_q;
        pc_d = pc_q;
        ptr_d = ptr_q;
        ctl_d = ctl_q;
        ip_d = ip_q;
        ius_d = ius_q;
        vhold_d = vhold_q && (i_mux_mode ? !ds_b : !rd_b);
        do_write = 1'b0;
        if (i_mux_mode && as_fall)
        begin
            // Address phase: with RJA bits 5:0, else bits 6:1
            addr_d = mic_q[`MIC_RJA_BIT] ? bus[5:0] : bus[6:1];
            addr_cs_d = !cs_b;
            addr_ack_d = !ack_b;
        end
        if (i_mux_mode)
            do_write = ds_fall && addr_cs_q && !dir && !addr_ack_q;
        else if (wr_fall && !cs_b && !ack_now)
        begin
            if (nm_ptr_phase)
            begin
                ptr_d = bus[5:0];
                ctl_d = pio_host_pkg::CTL_TARGET;
            end
            else
                do_write = 1'b1;
        end
        if (!i_mux_mode && rd_fall && !cs_b && !ack_now && rsel == `SEL_CTRL)
            ctl_d = pio_host_pkg::CTL_POINTER;
        if (!i_mux_mode && wr_fall && !cs_b && rsel == `SEL_CTRL && !nm_ptr_phase)
            ctl_d = pio_host_pkg::CTL_POINTER;
        if (do_write)
        begin
            if (in_reset)
            begin
                if (target == `REG_MIC)
                    mic_d[`MIC_RESET_BIT] = bus[`MIC_RESET_BIT];
            end
            else
            begin
                case (target)
                    `REG_MIC: mic_d = bus;
                    `REG_VECTOR: vec_d = bus;
                    `REG_PORT_A: pa_d = bus;
                    `REG_PORT_B: pb_d = bus;
                    `REG_PORT_C: pc_d = bus;
                    default: mic_d = mic_q;
                endcase
            end
        end
        // Pending flags set while running; the set wins over the vector fetch clear on the same edge, a strobe reset clears
        if (!in_reset && !(i_mux_mode && as_b && as_q && ds_b))
            ip_d = ip_q | i_event;
        // Vector fetch marks the highest pending source as under service
        if (ack_now && any_ip && grant_in && (i_mux_mode ? ds_fall : rd_fall))
        begin
            ius_d[hi_idx] = 1'b1;
            vhold_d = 1'b1;
            ip_d[hi_idx] = i_event[hi_idx];
        end
        if (strobe_reset)
        begin
            mic_d = `RESET_VAL;
            ptr_d = `REG_MIC;
            ctl_d = pio_host_pkg::CTL_POINTER;
            ip_d = '0;
            ius_d = '0;
            vhold_d = 1'b0;
        end
    end

    always_comb
    begin
        oe_d = do_read || do_vector;
        out_d = do_vector ? vec_q : rdata;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            as_q <= 1'b1;
            ds_q <= 1'b1;
            rd_q <= 1'b1;
            wr_q <= 1'b1;
            addr_q <= `REG_MIC;
            addr_cs_q <= 1'b0;
            addr_ack_q <= 1'b0;
            mic_q <= `RESET_VAL;
            vec_q <= `ZERO_BYTE;
            pa_q <= `ZERO_BYTE;
            pb_q <= `ZERO_BYTE;
            pc_q <= `ZERO_BYTE;
            ptr_q <= `REG_MIC;
            ctl_q <= pio_host_pkg::CTL_POINTER;
            ip_q <= '0;
            ius_q <= '0;
            out_q <= `ZERO_BYTE;
            oe_q <= 1'b0;
            vhold_q <= 1'b0;
        end
        else
        begin
            as_q <= as_d;
            ds_q <= ds_d;
            rd_q <= rd_d;
            wr_q <= wr_d;
            addr_q <= addr_d;
            addr_cs_q <= addr_cs_d;
            addr_ack_q <= addr_ack_d;
            mic_q <= mic_d;
            vec_q <= vec_d;
            pa_q <= pa_d;
            pb_q <= pb_d;
            pc_q <= pc_d;
            ptr_q <= ptr_d;
            ctl_q <= ctl_d;
            ip_q <= ip_d;
            ius_q <= ius_d;
            out_q <= out_d;
            oe_q <= oe_d;
            vhold_q <= vhold_d;
        end
    end

    // Request and daisy chain are registered so they change only on i_clk
    logic req_q, grant_q;
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            req_q <= 1'b0;
            grant_q <= 1'b0;
        end
        else
        begin
            req_q <= any_ip && mie && !in_reset;
            grant_q <= grant_in && (in_reset || (!any_ius && !(ack_now && any_ip)));
        end
    end
    assign o_service_request_out = 1'b0;
    assign o_service_request_oe = req_q;
    assign o_chain_grant_out = grant_q;
    assign o_bus_out = out_q;
    assign o_bus_oe = oe_q;
    assign o_in_reset = in_reset;
    assign o_port_a = pa_q;
    assign o_port_b = pb_q;
    assign o_port_c = pc_q;
    assign o_pending_flag = ip_q;
    assign o_service_flag = ius_q;
endmodule
`default_nettype wire

/* sim/pio_host_if_asserts.sv */
// Port-level assertion checker for the host bus interface
`timescale 1ns/1ps
`default_nettype none
`include "pio_host_regs.svh"
module pio_host_if_check #(
    parameter int NSRC = 3
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_mux_mode,
    input wire logic i_data_strobe_b,
    input wire logic i_chip_select_b,
    input wire logic i_read_strobe_b,
    input wire logic i_store_strobe_b,
    input wire logic [1:0] i_register_select_lines,
    input wire logic i_ack_cycle_b,
    input wire logic i_chain_grant_in,
    input wire logic [7:0] i_bus_in,
    input wire logic o_bus_oe,
    input wire logic o_chain_grant_out,
    input wire logic o_service_request_out,
    input wire logic o_service_request_oe,
    input wire logic o_in_reset,
    input wire logic [7:0] o_port_a,
    input wire logic [NSRC-1:0] o_pending_flag,
    input wire logic [NSRC-1:0] o_service_flag
);
    logic strb;
    // Strobe that may open the data drivers in the current variant
    assign strb = i_mux_mode ? !i_data_strobe_b : !i_read_strobe_b;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    a_grant_needs_in: assert property (!i_chain_grant_in [*4] |-> !o_chain_grant_out)
        else $error("grant out high while grant in low");
    a_serviced_blocks: assert property ((|o_service_flag && i_ack_cycle_b) [*4]
        |-> !o_chain_grant_out)
        else $error("grant out high while servicing");
    a_request_cause: assert property (o_service_request_oe |-> !o_service_request_out
        && ((|o_pending_flag) || $past(|o_pending_flag)))
        else $error("request without pending flag");
    a_reset_quiet: assert property (o_in_reset [*2] |-> !o_service_request_oe)
        else $error("request asserted in reset");
    a_bus_float: assert property (o_bus_oe |-> $past(strb, 3) || $past(strb, 4)
        || $past(strb, 5))
        else $error("bus driven without strobe");
    a_select_needed: assert property ((!i_mux_mode && i_chip_select_b && i_ack_cycle_b) [*6]
        |-> !o_bus_oe)
        else $error("bus driven while not selected");
    a_store_port_a: assert property (!i_mux_mode && !o_in_reset && !i_chip_select_b
        && $fell(i_store_strobe_b) && i_register_select_lines == `SEL_PORT_A
        |-> ##[3:6] (o_port_a == i_bus_in))
        else $error("port A write not captured");
    a_strobe_reset: assert property (!i_mux_mode && !i_read_strobe_b && !i_store_strobe_b
        |-> ##[2:6] o_in_reset)
        else $error("both strobes low did not reset");
    a_ack_grant_low: assert property ((!i_ack_cycle_b && |o_pending_flag) [*5]
        |-> !o_chain_grant_out)
        else $error("grant out high in acknowledge with pending");
    a_vector_service: assert property (!i_mux_mode && $fell(i_read_strobe_b) && !i_ack_cycle_b
        && i_chain_grant_in && (|o_pending_flag) |-> ##[3:6] (|o_service_flag))
        else $error("service flag not set by vector fetch");
    c_mux_read: cover property (o_bus_oe && i_mux_mode);
    c_serviced: cover property (|o_service_flag);
    c_reset_left: cover property (o_in_reset ##1 !o_in_reset);
endmodule
bind pio_host_if pio_host_if_check #(.NSRC(NSRC)) u_pio_host_if_check (.*);
`default_nettype wire

/* sim/host_bus_model.sv */
// Host side wiring: shared data bus and open-drain request line
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
    input wire logic i_clk,
    input wire logic i_host_oe,
    input wire logic [7:0] i_host_data,
    input wire logic i_dev_oe,
    input wire logic [7:0] i_dev_data,
    input wire logic i_req_oe,
    output logic [7:0] o_bus,
    output logic o_req_b
);
    logic [7:0] last_q;
    // A released bus toggles every cycle so stale data never looks valid
    always_ff @(posedge i_clk) last_q <= o_bus;
    assign o_bus = i_dev_oe ? i_dev_data : (i_host_oe ? i_host_data : ~last_q);
    assign o_req_b = !i_req_oe; // Pull-up
endmodule
`default_nettype wire

/* sim/pio_host_if_test.sv */
// Self-checking bench for the host bus interface, both variants
`timescale 1ns/1ps
`default_nettype none
`include "pio_host_regs.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module pio_host_if_test;
    logic clk, rst_b, mux, as_b, ds_b, dir, cs_b, rd_b, wr_b, ack_b, gin, hoe, seen;
    logic [1:0] sel;
    logic [2:0] ev, pend, serv;
    logic [7:0] hdat, bus, dout, pa, pb, pc, q;
    logic oe, gout, rq_out, rq_oe, in_rst, req_b;
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    pio_host_if u_pio_host_if (.i_clk(clk), .i_rst_b(rst_b), .i_mux_mode(mux),
        .i_address_strobe_b(as_b), .i_data_strobe_b(ds_b), .i_direction_in(dir),
        .i_chip_select_b(cs_b), .i_read_strobe_b(rd_b), .i_store_strobe_b(wr_b),
        .i_register_select_lines(sel), .i_ack_cycle_b(ack_b), .i_chain_grant_in(gin),
        .i_bus_in(bus), .i_event(ev), .o_bus_out(dout), .o_bus_oe(oe),
        .o_chain_grant_out(gout), .o_service_request_out(rq_out),
        .o_service_request_oe(rq_oe), .o_in_reset(in_rst), .o_port_a(pa), .o_port_b(pb),
        .o_port_c(pc), .o_pending_flag(pend), .o_service_flag(serv));
    host_bus_model u_host_bus_model (.i_clk(clk), .i_host_oe(hoe), .i_host_data(hdat),
        .i_dev_oe(oe), .i_dev_data(dout), .i_req_oe(rq_oe), .o_bus(bus), .o_req_b(req_b));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk; // Request logic in use, so never tied low
    end
    always @(posedge clk)
    begin
        cyc++;
        seen = seen | oe;
        if (cyc == 20000)
        begin
            errors++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Separate-bus access; four idle clocks after each keep the spacing
    task automatic acc(input logic c, input logic w, input logic [1:0] s,
        input logic [7:0] d, output logic [7:0] r);
        @(posedge clk);
        cs_b <= c;
        sel <= s;
        hoe <= w;
        hdat <= d;
        if (w) wr_b <= 1'b0;
        else rd_b <= 1'b0;
        repeat (6) @(posedge clk);
        r = bus;
        cs_b <= 1'b1;
        rd_b <= 1'b1;
        wr_b <= 1'b1;
        hoe <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    // Multiplexed access: strobe pulses on every access direction high reads
    task automatic mx(input logic w, input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] r);
        @(posedge clk);
        cs_b <= 1'b0;
        dir <= !w;
        hoe <= 1'b1;
        hdat <= a;
        as_b <= 1'b0;
        repeat (4) @(posedge clk);
        as_b <= 1'b1;
        hoe <= w;
        hdat <= d;
        repeat (2) @(posedge clk);
        ds_b <= 1'b0;
        repeat (6) @(posedge clk);
        r = bus;
        ds_b <= 1'b1;
        hoe <= 1'b0;
        cs_b <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
    task automatic ctl_wr(input logic [5:0] idx, input logic [7:0] d);
        acc(1'b0, 1'b1, `SEL_CTRL, {2'h0, idx}, q);
        acc(1'b0, 1'b1, `SEL_CTRL, d, q);
    endtask
    initial
    begin
        {rst_b, mux, sel, hoe, hdat, ev, seen} = '0;
        {as_b, ds_b, dir, cs_b, rd_b, wr_b, ack_b, gin} = '1;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK("in_reset", 1'b1, in_rst)
        acc(1'b0, 1'b1, `SEL_PORT_A, 8'hA5, q);
        `CHK("port_a_locked", 8'h00, pa)
        acc(1'b0, 1'b0, `SEL_PORT_A, 8'h00, q);
        `CHK("port_rd_reset", 8'h00, q)
        acc(1'b0, 1'b0, `SEL_CTRL, 8'h00, q);
        `CHK("ctl_rd_reset", `RESET_VAL, q)
        acc(1'b0, 1'b1, `SEL_CTRL, 8'h00, q);
        acc(1'b0, 1'b0, `SEL_CTRL, 8'h00, q);
        ctl_wr(`REG_MIC, 8'h00);
        `CHK("reset_clear", 1'b0, in_rst)
        for (int i = 0; i < 3; i++) acc(1'b0, 1'b1, 2'(i), 8'h30 + 8'(i), q);
        `CHK("port_c", 8'h30, pc)
        `CHK("port_b", 8'h31, pb)
        `CHK("port_a", 8'h32, pa)
        for (int i = 0; i < 3; i++)
        begin
            acc(1'b0, 1'b0, 2'(i), 8'h00, q);
            `CHK("port_rd", 8'h30 + 8'(i), q)
        end
        acc(1'b1, 1'b1, `SEL_PORT_A, 8'hEE, q);
        `CHK("port_a_unselected", 8'h32, pa)
        ctl_wr(`REG_PORT_A, 8'h3C);
        `CHK("ctl_target", 8'h3C, pa)
        acc(1'b0, 1'b1, `SEL_CTRL, {2'h0, `REG_PORT_B}, q);
        acc(1'b0, 1'b0, `SEL_CTRL, 8'h00, q);
        `CHK("ctl_rd", 8'h31, q)
        acc(1'b0, 1'b1, `SEL_CTRL, {2'h0, `REG_PORT_C}, q);
        acc(1'b0, 1'b0, `SEL_CTRL, 8'h00, q);
        `CHK("ctl_rd_after_rd", 8'h30, q)
        ctl_wr(`REG_VECTOR, 8'h40);
        ctl_wr(`REG_MIC, 8'h80);
        `CHK("grant_idle", 1'b1, gout)
        ev <= 3'h2;
        @(posedge clk);
        ev <= 3'h0;
        repeat (5) @(posedge clk);
        `CHK("pending", 1'b1, pend[1])
        `CHK("request_line", 1'b0, req_b)
        gin <= 1'b0;
        repeat (5) @(posedge clk);
        `CHK("grant_no_in", 1'b0, gout)
        gin <= 1'b1;
        // Acknowledge is driven on the clock and held for the whole cycle
        ack_b <= 1'b0;
        repeat (6) @(posedge clk);
        `CHK("grant_ack", 1'b0, gout)
        acc(1'b1, 1'b0, `SEL_PORT_C, 8'h00, q);
        `CHK("vector", 8'h40, q)
        `CHK("service", 1'b1, serv[1])
        ack_b <= 1'b1;
        repeat (5) @(posedge clk);
        `CHK("grant_serviced", 1'b0, gout)
        rd_b <= 1'b0;
        wr_b <= 1'b0;
        repeat (4) @(posedge clk);
        rd_b <= 1'b1;
        wr_b <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK("strobe_reset", 1'b1, in_rst)
        `CHK("request_reset", 1'b1, req_b)
        rst_b <= 1'b0;
        mux <= 1'b1;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        mx(1'b1, 8'h00, 8'h00, q);
        `CHK("mux_reset_clear", 1'b0, in_rst)
        mx(1'b1, {1'b0, `REG_PORT_A, 1'b0}, 8'h5A, q);
        `CHK("mux_write", 8'h5A, pa)
        mx(1'b0, {1'b0, `REG_PORT_A, 1'b0}, 8'h00, q);
        `CHK("mux_read", 8'h5A, q)
        mx(1'b1, 8'h00, 8'h02, q);
        mx(1'b1, {2'h0, `REG_PORT_B}, 8'h77, q);
        `CHK("mux_rja", 8'h77, pb)
        seen = 1'b0;
        mx(1'b0, {1'b0, 6'h3E, 1'b0}, 8'h00, q);
        `CHK("mux_no_reg", 1'b0, seen)
        final_report();
    end
endmodule
`default_nettype wire
